/* File: core/cpd_map.svh */
// Register offsets, field positions and reset values of the command decode.
// Assumes an 8-bit I/O port bus with single-cycle read and write strobes.
// Contract
// [R1] A command-port write with bit 4 low and bit 3 high goes to control word three.
// [R2] A command-port write with bit 4 low and bit 3 low goes to control word two.
// [R3] A command-port write with bit 4 high is init word one, whatever else it holds.
// [R4] Special mask field code 10 clears special mask mode, 11 sets it, 00 and 01 do nothing.
// [R5] Bit 2 set in a control word three write issues a poll command.
// [R6] Status select code 10 picks the request register, 11 the in-service one, else no change.
// [R7] Software writes bit 7 of control word three as zero; reads of the port return status.
// [R8] With the cascade enable bit low, control word writes change no other register.
// [R9] A write-only init word two at the data port holds vector base and legacy address bits.
// [R10] Each vector is the five base bits above the three-bit request level.
// [R11] Init word one resets the sequence; data writes step through words two, three, four.
// [R12] After a poll, the next command read returns present flag and top level, and acks it.
// [R13] The status read selection persists until a selecting control word three write.
`ifndef CPD_MAP_SVH
`define CPD_MAP_SVH
`define CPD_CMD_PORT       8'h24
`define CPD_DATA_PORT      8'h25
`define CPD_BIT_ICW1_SEL   4
`define CPD_BIT_OCW3_SEL   3
`define CPD_BIT_POLL       2
`define CPD_BIT_WORD_FOUR  0
`define CPD_SMM_HI         6
`define CPD_SMM_LO         5
`define CPD_RRS_HI         1
`define CPD_RRS_LO         0
`define CPD_VEC_HI         7
`define CPD_VEC_LO         3
`define CPD_SMM_CLEAR      2'h2
`define CPD_SMM_SET        2'h3
`define CPD_RRS_REQ        2'h2
`define CPD_RRS_ISR        2'h3
`define CPD_RST_VEC_BASE   5'h00
`define CPD_RST_SEL_ISR    1'b0
`endif

/* File: core/cpd_pkg.sv */
// Types shared by the command decode.
// Assumes the constants header is included by the design file.
package cpd_pkg;
  typedef enum logic [1:0] {
    CPD_IDLE,
    CPD_WANT_W2,
    CPD_WANT_W3,
    CPD_WANT_W4
  } cpd_init_type;
endpackage

/* File: core/cpd_command_decode.sv */
// Command and data port write decode of the cascaded slave controller.
// Assumes one-cycle wr_strobe/rd_strobe pulses with port_addr valid alongside.
`timescale 1ns/1ps
`include "cpd_map.svh"
module cpd_command_decode (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       cascade_enable_bit,
  input  wire logic [7:0] port_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  input  wire logic [7:0] request_status_reg,
  input  wire logic [7:0] in_service_status_reg,
  output logic      [7:0] rd_data,
  output logic            special_mask_mode,
  output logic            ocw2_write,
  output logic      [7:0] ocw2_data,
  output logic            icw1_write,
  output logic            poll_ack,
  output logic      [2:0] poll_ack_level,
  output logic      [7:0] vector_base,
  output logic            word_four_needed_flag,
  output logic            init_done,
  output logic      [2:0] request_level,
  output logic      [7:0] interrupt_vector
);

  logic [4:0]              vector_base_bits_reg;
  logic [2:0]              legacy_address_bits_reg;
  logic                    select_isr_reg;
  logic                    smm_reg;
  logic                    poll_pending_reg;
  logic                    word_four_reg;
  cpd_pkg::cpd_init_type   init_reg;
  logic                    cmd_wr;
  logic                    data_wr;
  logic                    word_two_wr;
  logic                    cmd_rd;
  logic                    is_icw1;
  logic                    ocw3_wr;
  logic                    is_ocw2;
  logic                    poll_hit;
  logic [2:0]              poll_level;

  // Lowest set bit is highest priority (fixed priority, rotation lives elsewhere)
  function automatic logic [2:0] top_level(input logic [7:0] req);
    top_level = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        top_level = 3'(i);
      end
    end
  endfunction

  // Address compare shared by the write and read decode
  function automatic logic port_hit(input logic [7:0] addr, input logic [7:0] target);
    port_hit = (addr == target);
  endfunction

  // Port decode; a bypassed slave ignores control words entirely
  assign cmd_wr  = wr_strobe && port_hit(port_addr, `CPD_CMD_PORT) && cascade_enable_bit;  // [R8]
  assign data_wr = wr_strobe && port_hit(port_addr, `CPD_DATA_PORT) && cascade_enable_bit; // [R8]
  assign cmd_rd  = rd_strobe && port_hit(port_addr, `CPD_CMD_PORT);
  assign is_icw1 = cmd_wr && wr_data[`CPD_BIT_ICW1_SEL];                               // [R3]
  assign ocw3_wr = cmd_wr && !wr_data[`CPD_BIT_ICW1_SEL] && wr_data[`CPD_BIT_OCW3_SEL]; // [R1]
  // Only the first data write after word one carries the vector base
  assign word_two_wr = data_wr && (init_reg == cpd_pkg::CPD_WANT_W2);  // [R9] [R11]
  assign is_ocw2 = cmd_wr && !wr_data[`CPD_BIT_ICW1_SEL] && !wr_data[`CPD_BIT_OCW3_SEL]; // [R2]
  assign poll_hit   = |request_status_reg;
  assign poll_level = top_level(request_status_reg);

  // Word-two strobe, one pulse per accepted write
  always_ff @(posedge clock) begin
    if (srst) begin
      ocw2_write <= 1'b0;
    end else begin
      ocw2_write <= is_ocw2;  // [R2]
    end
  end

  // Word-two data held until the next word-two write, so the pulse can be late-sampled
  always_ff @(posedge clock) begin
    if (srst) begin
      ocw2_data <= 8'h00;
    end else if (is_ocw2) begin
      ocw2_data <= wr_data;  // [R2]
    end
  end

  // Word-one strobe; restarts whatever init sequence was under way
  always_ff @(posedge clock) begin
    if (srst) begin
      icw1_write <= 1'b0;
    end else begin
      icw1_write <= is_icw1;  // [R3]
    end
  end

  // Special mask mode; codes 00 and 01 leave it alone
  always_ff @(posedge clock) begin
    if (srst) begin
      smm_reg <= 1'b0;
    end else if (ocw3_wr) begin
      if (wr_data[`CPD_SMM_HI:`CPD_SMM_LO] == `CPD_SMM_SET) begin
        smm_reg <= 1'b1;  // [R4]
      end else if (wr_data[`CPD_SMM_HI:`CPD_SMM_LO] == `CPD_SMM_CLEAR) begin
        smm_reg <= 1'b0;  // [R4]
      end
    end
  end

  // Status selection sticks until a selecting code arrives
  always_ff @(posedge clock) begin
    if (srst) begin
      select_isr_reg <= `CPD_RST_SEL_ISR;
    end else if (ocw3_wr && wr_data[`CPD_RRS_HI]) begin
      select_isr_reg <= wr_data[`CPD_RRS_LO];  // [R6] [R13]
    end
  end

  // Poll arms on word three, consumed by the next command read
  always_ff @(posedge clock) begin
    if (srst) begin
      poll_pending_reg <= 1'b0;
    end else if (ocw3_wr) begin
      poll_pending_reg <= wr_data[`CPD_BIT_POLL];  // [R5]
    end else if (cmd_rd) begin
      poll_pending_reg <= 1'b0;  // [R12]
    end
  end

  // Poll acknowledge, only when a request was really pending
  always_ff @(posedge clock) begin
    if (srst) begin
      poll_ack <= 1'b0;
    end else begin
      poll_ack <= cmd_rd && poll_pending_reg && poll_hit;  // [R12]
    end
  end

  // Level handed on with the acknowledge; held until the next poll read
  always_ff @(posedge clock) begin
    if (srst) begin
      poll_ack_level <= 3'h0;
    end else if (cmd_rd && poll_pending_reg) begin
      poll_ack_level <= poll_level;  // [R12]
    end
  end

  // Read data: poll answer first, else selected status; never the written word
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (cmd_rd && poll_pending_reg) begin
      rd_data <= {poll_hit, 4'h0, poll_level};  // [R12]
    end else if (cmd_rd) begin
      rd_data <= select_isr_reg ? in_service_status_reg : request_status_reg;  // [R7]
    end
  end

  // Init sequence; word three is mandatory since single mode is fixed off
  always_ff @(posedge clock) begin
    if (srst) begin
      init_reg <= cpd_pkg::CPD_IDLE;
    end else if (is_icw1) begin
      init_reg <= cpd_pkg::CPD_WANT_W2;  // [R11]
    end else if (data_wr) begin
      unique case (init_reg)
        cpd_pkg::CPD_WANT_W2: init_reg <= cpd_pkg::CPD_WANT_W3;  // [R11]
        cpd_pkg::CPD_WANT_W3: begin
          init_reg <= word_four_reg ? cpd_pkg::CPD_WANT_W4 : cpd_pkg::CPD_IDLE;  // [R11]
        end
        cpd_pkg::CPD_WANT_W4: init_reg <= cpd_pkg::CPD_IDLE;  // [R11]
        cpd_pkg::CPD_IDLE:    init_reg <= cpd_pkg::CPD_IDLE;
      endcase
    end
  end

  // Word-four request flag, taken afresh from every word one
  always_ff @(posedge clock) begin
    if (srst) begin
      word_four_reg <= 1'b0;
    end else if (is_icw1) begin
      word_four_reg <= wr_data[`CPD_BIT_WORD_FOUR];  // [R11]
    end
  end

  // Base vector bits from word two
  always_ff @(posedge clock) begin
    if (srst) begin
      vector_base_bits_reg <= `CPD_RST_VEC_BASE;
    end else if (word_two_wr) begin
      vector_base_bits_reg <= wr_data[`CPD_VEC_HI:`CPD_VEC_LO];  // [R9]
    end
  end

  // Legacy address bits; shown on the base output, never part of the vector
  always_ff @(posedge clock) begin
    if (srst) begin
      legacy_address_bits_reg <= 3'h0;
    end else if (word_two_wr) begin
      legacy_address_bits_reg <= wr_data[2:0];  // [R9]
    end
  end

  // Top pending level, registered alongside the vector so the two agree
  always_ff @(posedge clock) begin
    if (srst) begin
      request_level <= 3'h0;
    end else begin
      request_level <= poll_level;
    end
  end

  // Vector output: base bits over the current top request level
  always_ff @(posedge clock) begin
    if (srst) begin
      interrupt_vector <= 8'h00;
    end else begin
      interrupt_vector <= {vector_base_bits_reg, poll_level};  // [R10]
    end
  end

  assign special_mask_mode     = smm_reg;
  assign vector_base           = {vector_base_bits_reg, legacy_address_bits_reg};
  assign word_four_needed_flag = word_four_reg;
  assign init_done             = (init_reg == cpd_pkg::CPD_IDLE);

endmodule

/* File: test/cpd_host_model.sv */
// Host processor model: issues port reads and writes to the decode.
// Assumes the bench calls acc; strobes change on falling clock edges.
`timescale 1ns/1ps
module cpd_host_model (
  input  wire logic       clock,
  output logic      [7:0] port_addr,
  output logic      [7:0] wr_data,
  output logic            wr_strobe,
  output logic            rd_strobe
);
  initial {port_addr, wr_data, wr_strobe, rd_strobe} = '0;
  // One access per call; a released bus shows inverted junk, never the last value
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {port_addr, wr_data, wr_strobe, rd_strobe} = {a, d, w, !w};
    @(negedge clock);
    {port_addr, wr_data, wr_strobe, rd_strobe} = {~a, ~d, 2'b00};
  endtask
endmodule

/* File: test/cpd_properties.sv */
// Checker of the command decode, bound to its ports.
// Assumes the one-cycle answer of the port contract.
`timescale 1ns/1ps
module cpd_properties (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       cascade_enable_bit,
  input wire logic [7:0] port_addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_strobe,
  input wire logic       rd_strobe,
  input wire logic [7:0] request_status_reg,
  input wire logic [7:0] rd_data,
  input wire logic       special_mask_mode,
  input wire logic       ocw2_write,
  input wire logic       icw1_write,
  input wire logic       poll_ack,
  input wire logic [7:0] vector_base,
  input wire logic       init_done,
  input wire logic [2:0] request_level,
  input wire logic [7:0] interrupt_vector
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Accepted command and data port writes
  sequence cw_s; wr_strobe && cascade_enable_bit && port_addr == 8'h24; endsequence
  sequence dw_s; wr_strobe && cascade_enable_bit && port_addr == 8'h25; endsequence
  mask_set_a: assert property (cw_s ##0 wr_data[6:3] == 4'hd |=> special_mask_mode)
    else $error("mask not set");
  mask_clear_a: assert property (cw_s ##0 wr_data[6:3] == 4'h9 |=> !special_mask_mode)
    else $error("mask not cleared");
  word_two_route_a: assert property (cw_s ##0 wr_data[4:3] == 2'h0 |=> ocw2_write)
    else $error("word two missed");
  word_one_route_a: assert property (cw_s ##0 wr_data[4] |=> icw1_write && !init_done)
    else $error("word one missed");
  bypass_quiet_a: assert property (wr_strobe && !cascade_enable_bit
    |=> !icw1_write && !ocw2_write && $stable(special_mask_mode)) else $error("bypass leak");
  vector_form_a: assert property ($stable(vector_base) && $stable(request_level)
    |-> interrupt_vector == {vector_base[7:3], request_level}) else $error("bad vector");
  base_load_a: assert property (cw_s ##0 wr_data[4] ##2 dw_s
    |=> vector_base == $past(wr_data)) else $error("base not loaded");
  poll_answer_a: assert property (cw_s ##0 wr_data[4:2] == 3'h3
    ##2 (rd_strobe && port_addr == 8'h24)
    |=> rd_data[6:3] == 4'h0 && poll_ack == rd_data[7]
    && rd_data[7] == ($past(request_status_reg) != 8'h00)) else $error("bad poll");
endmodule
bind cpd_command_decode cpd_properties u_props (.clock, .srst, .cascade_enable_bit,
  .port_addr, .wr_data, .wr_strobe, .rd_strobe, .request_status_reg, .rd_data,
  .special_mask_mode, .ocw2_write, .icw1_write, .poll_ack, .vector_base, .init_done,
  .request_level, .interrupt_vector);

/* File: test/tb.sv */
// Bench of the command decode driven through the host model.
// Assumes the one-cycle answer and reset values of the port contract.
`timescale 1ns/1ps
module tb;
  logic       clock = 0, srst = 1, en = 1, wr_strobe, rd_strobe, smm, o2, i1, pa, wf, dn;
  logic [7:0] rq = 0, is = 8'h5a, port_addr, wr_data, rd, vb, iv, od;
  logic [2:0] pl, lv;
  int         bad_count = 0, n_tests = 0;
  // Rows: command byte, then expected mask, word two pulse, word one pulse
  logic [10:0] rows [6] = '{11'h344, 11'h144, 11'h044, 11'h306, 11'h240, 11'h3f1};
  logic [7:0]  sel [3] = '{8'h0b, 8'h09, 8'h0a};
  cpd_host_model host (.clock, .port_addr, .wr_data, .wr_strobe, .rd_strobe);
  cpd_command_decode DUT (.clock, .srst, .cascade_enable_bit(en), .port_addr, .wr_data,
    .wr_strobe, .rd_strobe, .request_status_reg(rq), .in_service_status_reg(is), .rd_data(rd),
    .special_mask_mode(smm), .ocw2_write(o2), .ocw2_data(od), .icw1_write(i1), .poll_ack(pa),
    .poll_ack_level(pl), .vector_base(vb), .word_four_needed_flag(wf), .init_done(dn),
    .request_level(lv), .interrupt_vector(iv));
  initial forever #12.5 clock = ~clock;
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100us;
    bad_count++;
    tally_and_finish;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clock);
    srst = 0;
    foreach (rows[i]) begin
      host.acc(1, 8'h24, rows[i][10:3]);
      chk("mask", rows[i][2], smm);
      chk("wtwo", rows[i][1], o2);
      chk("wone", rows[i][0], i1);
    end
    chk("wdat", 8'h60, od);
    chk("done", 0, dn);
    host.acc(1, 8'h25, 8'hf0);
    chk("base", 8'hf0, vb);
    host.acc(1, 8'h25, 8'h05);
    chk("done", 1, dn);
    rq = 8'h0c;
    host.acc(1, 8'h25, 8'h33);
    chk("base", 8'hf0, vb);
    chk("vec", 8'hf2, iv);
    chk("lvl", 8'h02, lv);
    host.acc(1, 8'h24, 8'h11);
    chk("four", 1, wf);
    host.acc(1, 8'h25, 8'ha8);
    host.acc(1, 8'h25, 8'h05);
    chk("done", 0, dn);
    host.acc(1, 8'h25, 8'h00);
    chk("done", 1, dn);
    chk("vec", 8'haa, iv);
    $display("init tests done");
    host.acc(0, 8'h24, 8'h00);
    chk("read", rq, rd);
    foreach (sel[i]) begin
      host.acc(1, 8'h24, sel[i]);
      host.acc(0, 8'h24, 8'h00);
      chk("read", sel[i][0] ? is : rq, rd);
    end
    for (int k = 0; k < 2; k++) begin
      rq = k ? 8'h00 : 8'h0c;
      host.acc(1, 8'h24, 8'h0c);
      host.acc(0, 8'h24, 8'h00);
      chk("poll", k ? 8'h00 : 8'h82, rd);
      chk("ack", !k, pa);
      chk("plvl", k ? 8'h00 : 8'h02, pl);
    end
    rq = 8'h0c;
    host.acc(0, 8'h24, 8'h00);
    chk("read", rq, rd);
    en = 0;
    host.acc(1, 8'h24, 8'h68);
    chk("mask", 0, smm);
    host.acc(1, 8'h24, 8'h11);
    chk("wone", 0, i1);
    chk("done", 1, dn);
    en = 1;
    host.acc(1, 8'h24, 8'h68);
    chk("mask", 1, smm);
    host.acc(1, 8'h24, 8'h11);
    chk("done", 0, dn);
    srst = 1;
    repeat (16) @(negedge clock);
    srst = 0;
    chk("mask", 0, smm);
    chk("done", 1, dn);
    chk("four", 0, wf);
    chk("base", 8'h00, vb);
    $display("status and reset tests done");
    tally_and_finish;
  end
endmodule
